//--- prot_map.svh
/*
 * offsets, field positions, reset values and sizes of the region checker
 * assumes: included by bare name from every file that needs a constant
 */
`ifndef PROT_MAP_SVH
`define PROT_MAP_SVH

// table sizes
`define RGN_COUNT      16
`define PORT_COUNT     2

// word index of each 32-bit part of a 128-bit descriptor
`define WORD_START     2'h0
`define WORD_END       2'h1
`define WORD_ACW       2'h2
`define WORD_CTRL      2'h3

// region granule is 32 bytes: low address bits are implied
`define GRAN_LSB       5

// access control word field positions
`define ACW_SUP_LSB    0
`define ACW_USR_LSB    3
`define ACW_DMA_LSB    6
`define ACW_OTH_LSB    8
`define PERM_R         0
`define PERM_W         1
`define PERM_X         2

// control word field position
`define CTRL_VALID_BIT 0

// reset values
`define ADDR_RST       32'h0000_0000
`define ACW_RST        32'h0000_0000
`define ERR_RST        64'h0000_0000_0000_0000

`endif

//--- prot_pkg.sv
/*
 * types shared by the region checker modules
 * assumes: nothing beyond a SystemVerilog compiler
 */
package prot_pkg;

   // crossbar master identity carried with each transfer
   typedef enum logic [1:0] {
      mst_core_instr,
      mst_core_data,
      mst_dma,
      mst_other
   } master_t;

   // captured details of the most recent faulting access
   typedef struct packed {
      logic [10:0] pad;
      logic        sup_mode;
      logic        exec;
      logic        write;
      master_t     master;
      logic [15:0] hit;
      logic [31:0] addr;
   } err_record_t;

endpackage

//--- region_if.sv
/*
 * descriptor table as seen by the store and by the per-port checkers
 * assumes: one store drives it, any number of checkers read it
 */
`timescale 1ns/1ps

interface region_if;
   logic [15:0][31:0] start_addr;
   logic [15:0][31:0] end_addr;
   logic [15:0][31:0] acw;
   logic [15:0]       valid;

   modport store (output start_addr, output end_addr, output acw,
                  output valid);
   modport check (input start_addr, input end_addr, input acw,
                  input valid);
endinterface

//--- region_store.sv
/*
 * sixteen 128-bit region descriptors with registered readback
 * assumes: one writer, writes and reads on the same clock
 */
`timescale 1ns/1ps
`include "prot_map.svh"

module region_store
   import prot_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wr_en,
   input  wire logic        acw_wr_en,
   input  wire logic [3:0]  wr_idx,
   input  wire logic [1:0]  wr_word,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  rd_idx,
   input  wire logic [1:0]  rd_word,
   output      logic [31:0] rd_data,
   region_if.store          rgn
);

   // readback selection; the control word shows only the valid bit
   wire [31:0] rd_sel =
      (rd_word == `WORD_START) ? rgn.start_addr[rd_idx] :
      (rd_word == `WORD_END)   ? rgn.end_addr[rd_idx] :
      (rd_word == `WORD_ACW)   ? rgn.acw[rd_idx] :
      {31'h0000_0000, rgn.valid[rd_idx]};

   // start/end forced to 32-byte granules, so sizes run 32 B..4 GB
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rgn.start_addr <= {16{`ADDR_RST}};
         rgn.end_addr   <= {16{`ADDR_RST}};
         rgn.acw        <= {16{`ACW_RST}};
         rgn.valid      <= 16'h0000;
      end
      else if (wr_en)
      begin
         case (wr_word)
            `WORD_START:
            begin
               rgn.start_addr[wr_idx] <=
                  {wdata[31:`GRAN_LSB], {`GRAN_LSB{1'b0}}};
               rgn.valid[wr_idx] <= 1'b0;
            end
            `WORD_END:
            begin
               rgn.end_addr[wr_idx] <=
                  {wdata[31:`GRAN_LSB], {`GRAN_LSB{1'b1}}};
               rgn.valid[wr_idx] <= 1'b0;
            end
            `WORD_ACW:
            begin
               rgn.acw[wr_idx]   <= wdata;
               rgn.valid[wr_idx] <= 1'b0;
            end
            default:
               rgn.valid[wr_idx] <= wdata[`CTRL_VALID_BIT];
         endcase
      end
      else if (acw_wr_en)
         rgn.acw[wr_idx] <= wdata; // rights only, valid untouched
   end

   // readback comes out of a register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rd_data <= 32'h0000_0000;
      else
         rd_data <= rd_sel;
   end

endmodule

//--- region_match.sv
/*
 * checks one transfer against all descriptors at once
 * assumes: purely combinational; descriptor table from region_if
 */
`timescale 1ns/1ps
`include "prot_map.svh"

module region_match
   import prot_pkg::*;
(
   region_if.check          rgn,
   input  wire logic [31:0] addr,
   input  wire master_t     master,
   input  wire logic        write,
   input  wire logic        exec,
   input  wire logic        sup_mode,
   output      logic [15:0] hit,
   output      logic [15:0] grant
);

   // core masters use rwx sets, others a read/write pair
   wire is_core = (master == mst_core_instr) ||
                  (master == mst_core_data);

   genvar i;
   generate
      for (i = 0; i < `RGN_COUNT; i++)
      begin : g_rgn
         // inclusive bounds on both ends
         wire in_range = rgn.valid[i] &&
                         (addr >= rgn.start_addr[i]) &&
                         (addr <= rgn.end_addr[i]);
         wire [2:0] rwx = sup_mode ?
            rgn.acw[i][`ACW_SUP_LSB +: 3] :
            rgn.acw[i][`ACW_USR_LSB +: 3];
         wire [1:0] rw = (master == mst_dma) ?
            rgn.acw[i][`ACW_DMA_LSB +: 2] :
            rgn.acw[i][`ACW_OTH_LSB +: 2];
         wire core_ok = exec  ? rwx[`PERM_X] :
                        write ? rwx[`PERM_W] : rwx[`PERM_R];
         // a non-core fetch has no execute right, so it counts as a read
         wire bus_ok  = (write && !exec) ? rw[`PERM_W] : rw[`PERM_R];
         assign hit[i]   = in_range;
         assign grant[i] = in_range && (is_core ? core_ok : bus_ok);
      end
   endgenerate

endmodule

//--- bus_region_access_checker.sv
/*
 * protection unit on the SRAM and peripheral bridge slave ports of the
 * crossbar switch: sixteen region descriptors, per-port access checks,
 * error termination and per-port fault records
 * assumes: transfer attributes come from logic on the same clock;
 * descriptor writes come from a plain software-facing port
 */
`timescale 1ns/1ps
`include "prot_map.svh"

// What this block does
// - sixteen region descriptors, each a 128-bit record of range and rights
// - start and end addresses bound each region, 32 bytes up to 4 GB
// - after reset the unit is invalid and lets every transfer through
// - core master: separate read, write, execute for supervisor and user
// - other masters: only read and write rights, no execute
// - hardware clears a descriptor's valid bit when desc_wr_en rewrites its start, end or rights word
// - alternate write of the access control word alone, addresses kept
// - overlapping regions: any granting region permits the access
// - checks every access on SRAM and bridge ports against all regions
// - a transfer with sufficient rights goes on to the slave normally
// - error when no valid region hits or all hitting regions deny
// - an error ends the transfer with error response, slave not reached
// - one 64-bit record per port holds the latest faulting access
module bus_region_access_checker
   import prot_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             unit_enable_set,
   input  wire logic             unit_enable_clear,
   output      logic             unit_active,
   input  wire logic             desc_wr_en,
   input  wire logic             desc_acw_wr_en,
   input  wire logic [3:0]       desc_index,
   input  wire logic [1:0]       desc_word,
   input  wire logic [31:0]      desc_wdata,
   input  wire logic [3:0]       desc_rd_index,
   input  wire logic [1:0]       desc_rd_word,
   output      logic [31:0]      desc_rd_data,
   output      logic [15:0]      desc_valid,
   input  wire logic [1:0]       xfer_valid,
   input  wire logic [1:0][31:0] xfer_addr,
   input  wire logic [1:0][1:0]  xfer_master,
   input  wire logic [1:0]       xfer_write,
   input  wire logic [1:0]       xfer_exec,
   input  wire logic [1:0]       xfer_super,
   output      logic [1:0]       slave_valid,
   output      logic [1:0]       xfer_error,
   output      logic [1:0][63:0] err_record,
   output      logic [1:0]       err_flag,
   input  wire logic [1:0]       err_clear
);

   region_if rgn ();

   // descriptor table; readback is registered inside the store
   region_store u_store (
      .clk       (clk),
      .rst       (rst),
      .wr_en     (desc_wr_en),
      .acw_wr_en (desc_acw_wr_en),
      .wr_idx    (desc_index),
      .wr_word   (desc_word),
      .wdata     (desc_wdata),
      .rd_idx    (desc_rd_index),
      .rd_word   (desc_rd_word),
      .rd_data   (desc_rd_data),
      .rgn       (rgn.store)
   );

   // valid bits are registers in the store, shown as status
   assign desc_valid = rgn.valid;

   // global enable: starts invalid, set wins over a same-cycle clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         unit_active <= 1'b0;
      else if (unit_enable_set)
         unit_active <= 1'b1;
      else if (unit_enable_clear)
         unit_active <= 1'b0;
   end

   // port 0 is the SRAM port, port 1 the peripheral bridge port
   genvar p;
   genvar r;
   generate
      for (p = 0; p < `PORT_COUNT; p++)
      begin : g_port
         logic [15:0] hit;
         logic [15:0] grant;
         err_record_t next_rec;

         // every region compared in parallel on each port
         region_match u_match (
            .rgn      (rgn.check),
            .addr     (xfer_addr[p]),
            .master   (master_t'(xfer_master[p])),
            .write    (xfer_write[p]),
            .exec     (xfer_exec[p]),
            .sup_mode (xfer_super[p]),
            .hit      (hit),
            .grant    (grant)
         );

         // the verdict is combinational so no transfer is ever stalled;
         // the cost is a 16-way compare chain in the slave address path
         // any single granting region is enough; denials never veto
         wire allowed = (|grant) || !unit_active;
         wire fault   = xfer_valid[p] && !allowed;

         // handshake outputs are combinational so a fault never leaks
         assign slave_valid[p] = xfer_valid[p] && allowed;
         assign xfer_error[p]  = fault;

         // record of the access being refused this cycle
         assign next_rec.pad      = 11'h000;
         assign next_rec.sup_mode = xfer_super[p];
         assign next_rec.exec     = xfer_exec[p];
         assign next_rec.write    = xfer_write[p];
         assign next_rec.master   = master_t'(xfer_master[p]);
         assign next_rec.hit      = hit;
         assign next_rec.addr     = xfer_addr[p];

         // only faults update the record, so it keeps the latest one
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               err_record[p] <= `ERR_RST;
            else if (fault)
               err_record[p] <= next_rec;
         end

         // sticky fault flag; a new fault beats a same-cycle clear
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
               err_flag[p] <= 1'b0;
            else if (fault)
               err_flag[p] <= 1'b1;
            else if (err_clear[p])
               err_flag[p] <= 1'b0;
         end

         // inactive unit passes everything untouched
         chk_pass_when_off: assert property (
            @(posedge clk) disable iff (rst)
            (!unit_active && xfer_valid[p]) |-> slave_valid[p]
         ) else $error("transfer held back while unit inactive");

         // a hit with no rights and no other grant must fault
         chk_nohit_faults: assert property (
            @(posedge clk) disable iff (rst)
            (unit_active && xfer_valid[p] && (grant == 16'h0000))
               |-> (xfer_error[p] && !slave_valid[p])
         ) else $error("unmapped or denied access not flagged");

         // one granting region wins over any number of denials
         chk_grant_wins: assert property (
            @(posedge clk) disable iff (rst)
            (xfer_valid[p] && (grant != 16'h0000))
               |-> (slave_valid[p] && !xfer_error[p])
         ) else $error("granted access was refused");

         // error and forwarding are mutually exclusive
         chk_error_blocks: assert property (
            @(posedge clk) disable iff (rst)
            xfer_error[p] |-> (!slave_valid[p] && xfer_valid[p])
         ) else $error("faulting cycle reached the slave");

         // legal transfer goes through in the same cycle
         chk_legal_passes: assert property (
            @(posedge clk) disable iff (rst)
            (xfer_valid[p] && !xfer_error[p]) |-> slave_valid[p]
         ) else $error("legal transfer not forwarded");

         // the record holds the faulting address one cycle later
         chk_record_addr: assert property (
            @(posedge clk) disable iff (rst)
            xfer_error[p] |=> (err_record[p][31:0] == $past(xfer_addr[p])
                               && err_flag[p])
         ) else $error("fault record missing the faulting address");

         // record stays put while no new fault arrives
         chk_record_hold: assert property (
            @(posedge clk) disable iff (rst)
            !xfer_error[p] |=> $stable(err_record[p])
         ) else $error("fault record changed without a fault");

         // every region's hit follows its inclusive range, ends included
         for (r = 0; r < `RGN_COUNT; r++)
         begin : g_bound
            chk_hit_bounds: assert property (
               @(posedge clk) disable iff (rst)
               hit[r] == (rgn.valid[r] &&
                          xfer_addr[p] >= rgn.start_addr[r] &&
                          xfer_addr[p] <= rgn.end_addr[r])
            ) else $error("region hit disagrees with its bounds");
         end

         // the record also keeps who faulted, how, and which regions hit
         chk_record_attr: assert property (
            @(posedge clk) disable iff (rst)
            xfer_error[p] |=> (err_record[p][52:32] ==
                               $past({xfer_super[p], xfer_exec[p],
                                      xfer_write[p], xfer_master[p],
                                      hit}))
         ) else $error("fault record missing the access attributes");

         // a clear with no new fault empties the flag
         chk_flag_clear: assert property (
            @(posedge clk) disable iff (rst)
            (err_clear[p] && !xfer_error[p]) |=> !err_flag[p]
         ) else $error("fault flag not cleared");

         // the flag stays up until software clears it
         chk_flag_sticky: assert property (
            @(posedge clk) disable iff (rst)
            (err_flag[p] && !err_clear[p]) |=> err_flag[p]
         ) else $error("fault flag dropped on its own");

         // nothing is forwarded or refused without a transfer
         chk_idle_quiet: assert property (
            @(posedge clk) disable iff (rst)
            !xfer_valid[p] |-> (!slave_valid[p] && !xfer_error[p])
         ) else $error("port active with no transfer present");

         // an inactive unit never raises a protection error
         chk_error_needs_on: assert property (
            @(posedge clk) disable iff (rst)
            xfer_error[p] |-> unit_active
         ) else $error("error raised while unit inactive");
      end
   endgenerate

   // rewriting a start address drops the valid bit at once
   chk_valid_drop: assert property (
      @(posedge clk) disable iff (rst)
      (desc_wr_en && desc_word == `WORD_START)
         |=> !desc_valid[$past(desc_index)]
   ) else $error("descriptor kept valid while being rewritten");

   // alternate rights view leaves the valid bits alone
   chk_acw_keeps_valid: assert property (
      @(posedge clk) disable iff (rst)
      (desc_acw_wr_en && !desc_wr_en) |=> $stable(desc_valid)
   ) else $error("rights-only write disturbed valid bits");

   // enable takes effect on the next edge, even with a clear in the same cycle
   chk_enable_set: assert property (
      @(posedge clk) disable iff (rst)
      unit_enable_set |=> unit_active
   ) else $error("unit enable not taken");

   // clear without set turns the unit off on the next edge
   chk_enable_clear: assert property (
      @(posedge clk) disable iff (rst)
      (unit_enable_clear && !unit_enable_set) |=> !unit_active
   ) else $error("unit disable not taken");

   // the enable only moves on a set or clear request
   chk_enable_hold: assert property (
      @(posedge clk) disable iff (rst)
      (!unit_enable_set && !unit_enable_clear) |=> $stable(unit_active)
   ) else $error("unit enable changed with no request");

   // rewriting an end address or rights word also drops the valid bit
   chk_valid_drop_rest: assert property (
      @(posedge clk) disable iff (rst)
      (desc_wr_en && (desc_word == `WORD_END || desc_word == `WORD_ACW))
         |=> !desc_valid[$past(desc_index)]
   ) else $error("descriptor kept valid while being rewritten");

   // a control word write sets the valid bit from data bit 0
   chk_valid_set: assert property (
      @(posedge clk) disable iff (rst)
      (desc_wr_en && desc_word == `WORD_CTRL)
         |=> desc_valid[$past(desc_index)] == $past(desc_wdata[0])
   ) else $error("control word write did not set the valid bit");

   // rights-only write lands in the access control word
   chk_acw_view: assert property (
      @(posedge clk) disable iff (rst)
      (desc_acw_wr_en && !desc_wr_en)
         |=> rgn.acw[$past(desc_index)] == $past(desc_wdata)
   ) else $error("rights-only write not stored");

   // an end address covers the whole of its last 32-byte granule
   chk_end_granule: assert property (
      @(posedge clk) disable iff (rst)
      (desc_wr_en && desc_word == `WORD_END)
         |=> (rgn.end_addr[$past(desc_index)][`GRAN_LSB-1:0] ==
              {`GRAN_LSB{1'b1}})
   ) else $error("end address does not cover its granule");

   // a start address always sits on a 32-byte granule boundary
   chk_start_granule: assert property (
      @(posedge clk) disable iff (rst)
      (desc_wr_en && desc_word == `WORD_START)
         |=> (rgn.start_addr[$past(desc_index)][`GRAN_LSB-1:0] ==
              {`GRAN_LSB{1'b0}})
   ) else $error("start address off its granule");

endmodule

//--- slave_port_model.sv
/*
 * protected slave side: counts the beats that reach each slave port
 * assumes: slave_valid and xfer_error come from the checker, same clock
 */
`timescale 1ns/1ps

module slave_port_model
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [1:0] slave_valid,
   input  wire logic [1:0] xfer_error,
   output      int         reach_sram,
   output      int         reach_bridge
);
   // a refused beat must never be seen here, so both flags gate the count
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         reach_sram   <= 0;
         reach_bridge <= 0;
      end
      else
      begin
         reach_sram   <= reach_sram + (slave_valid[0] && !xfer_error[0]);
         reach_bridge <= reach_bridge + (slave_valid[1] && !xfer_error[1]);
      end
   end
endmodule

//--- tb_bus_region_access_checker.sv
/*
 * bench for the region checker: random transfers against a table model
 * assumes: package, interface, design and slave model compiled first
 */
`timescale 1ns/1ps

module tb_bus_region_access_checker;
   import prot_pkg::*;
   logic             clk, rst, en_set, en_clr, wr, awr, act;
   logic [3:0]       idx, ridx;
   logic [1:0]       word, rword, xv, xw, xx, xs, slv, xe, ef, ec;
   logic [31:0]      wd, rdat;
   logic [15:0]      dval;
   logic [1:0][31:0] xa;
   logic [1:0][1:0]  xm;
   logic [1:0][63:0] er;
   int               reach0, reach1, exp_reach[2], err_total, checks, cyc_n;
   bit   [31:0]      st[16], en[16], acw[16];
   bit   [15:0]      vld;
   bit               m_act;
   bit   [1:0]       m_flag;
   bit   [63:0]      m_rec[2];

   bus_region_access_checker u_bus_region_access_checker (
      .clk(clk), .rst(rst), .unit_enable_set(en_set),
      .unit_enable_clear(en_clr), .unit_active(act), .desc_wr_en(wr),
      .desc_acw_wr_en(awr), .desc_index(idx), .desc_word(word),
      .desc_wdata(wd), .desc_rd_index(ridx), .desc_rd_word(rword),
      .desc_rd_data(rdat), .desc_valid(dval), .xfer_valid(xv),
      .xfer_addr(xa), .xfer_master(xm), .xfer_write(xw), .xfer_exec(xx),
      .xfer_super(xs), .slave_valid(slv), .xfer_error(xe),
      .err_record(er), .err_flag(ef), .err_clear(ec));

   slave_port_model u_slave_port_model (
      .clk(clk), .rst(rst), .slave_valid(slv), .xfer_error(xe),
      .reach_sram(reach0), .reach_bridge(reach1));

   // clock, plus a cycle ceiling so a hang still reaches the verdict
   initial
   begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc_n++;
      if (cyc_n == 2000)
      begin
         err_total++;
         give_verdict;
      end
   end

   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
      checks++;
      if (s !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   // inputs always move 2 ns after the rising edge
   task automatic step;
      @(posedge clk);
      #2;
   endtask

   // model decision for one port: {allowed, hit vector}
   function automatic bit [16:0] judge(int p);
      bit [15:0] h;
      bit        ok;
      int        b;
      h = '0;
      ok = 0;
      for (int r = 0; r < 16; r++)
      begin
         if (vld[r] && xa[p] >= st[r] && xa[p] <= en[r])
         begin
            h[r] = 1;
            if (xm[p] < 2)
               b = (xs[p] ? 0 : 3) + (xx[p] ? 2 : xw[p]);
            else
               b = (xm[p] == 2 ? 6 : 8) + (xw[p] & !xx[p]);
            ok |= acw[r][b];
         end
      end
      return {ok | !m_act, h};
   endfunction

   // compare the same-cycle answer, advance the model, compare registers
   task automatic tick;
      bit [16:0] j[2];
      #10;
      for (int p = 0; p < 2; p++)
      begin
         j[p] = judge(p);
         chk("slave_valid", xv[p] & j[p][16], slv[p]);
         chk("xfer_error", xv[p] & !j[p][16], xe[p]);
         exp_reach[p] += xv[p] & j[p][16];
         if (ec[p])
            m_flag[p] = 0;
         if (xv[p] && !j[p][16])
         begin
            m_flag[p] = 1;
            m_rec[p] = {11'h0, xs[p], xx[p], xw[p], xm[p], j[p][15:0], xa[p]};
         end
      end
      if (wr)
      begin
         case (word)
            2'h0: st[idx] = wd & 32'hffff_ffe0;
            2'h1: en[idx] = wd | 32'h0000_001f;
            2'h2: acw[idx] = wd;
            default: ;
         endcase
         vld[idx] = (word == 2'h3) ? wd[0] : 1'b0;
      end
      else if (awr)
         acw[idx] = wd;
      if (en_set)
         m_act = 1;
      else if (en_clr)
         m_act = 0;
      step;
      chk("unit_active", m_act, act);
      chk("desc_valid", vld, dval);
      for (int p = 0; p < 2; p++)
      begin
         chk("err_flag", m_flag[p], ef[p]);
         chk("err_record", m_rec[p], er[p]);
      end
   endtask

   // random attributes; addresses lean on region edges and outside them
   task automatic rand_xfer;
      int r;
      for (int p = 0; p < 2; p++)
      begin
         r = $urandom_range(0, 15);
         xv[p] = $urandom_range(0, 3) != 0;
         case ($urandom_range(0, 3))
            0: xa[p] = $urandom;
            1: xa[p] = st[r] - $urandom_range(0, 1);
            2: xa[p] = en[r] + $urandom_range(0, 1);
            default: xa[p] = $urandom_range(0, 2047);
         endcase
         xm[p] = $urandom;
         xw[p] = $urandom;
         xx[p] = $urandom;
         xs[p] = $urandom;
         ec[p] = $urandom_range(0, 7) == 0;
      end
   endtask

   task automatic readback;
      bit [31:0] e;
      xv = '0;
      ec = '0;
      for (int i = 0; i < 64; i++)
      begin
         ridx = i[5:2];
         rword = i[1:0];
         step;
         e = (rword == 0) ? st[ridx] : (rword == 1) ? en[ridx] :
             (rword == 2) ? acw[ridx] : {31'h0, vld[ridx]};
         chk("desc_rd_data", e, rdat);
      end
   endtask

   // reset, program all regions, then random traffic with rewrites
   initial
   begin
      rst = 1;
      {en_set, en_clr, wr, awr, idx, ridx, word, rword} = '0;
      {wd, xv, xa, xm, xw, xx, xs, ec} = '0;
      void'($urandom(74));
      repeat (20) @(posedge clk);
      #2;
      rst = 0;
      repeat (30)
      begin
         rand_xfer;
         tick;
      end
      wr = 1;
      for (int i = 0; i < 64; i++)
      begin
         idx = i[5:2];
         word = i[1:0];
         wd = (word == 3) ? 32'h1 : $urandom_range(0, 1023) + 1024 * word;
         rand_xfer;
         tick;
      end
      wr = 0;
      readback;
      for (int i = 0; i < 400; i++)
      begin
         en_set = (i == 0 || i == 350);
         en_clr = (i == 300 || i == 350);
         wr = $urandom_range(0, 15) == 0;
         awr = $urandom_range(0, 7) == 0;
         idx = $urandom;
         word = $urandom;
         wd = $urandom_range(0, 1023) + (word == 1 ? 1024 : 0);
         rand_xfer;
         tick;
      end
      {en_set, en_clr, wr, awr} = '0;
      readback;
      chk("reach_sram", exp_reach[0], reach0);
      chk("reach_bridge", exp_reach[1], reach1);
      give_verdict;
   end
endmodule
